// ### pkg/dea_pkg.sv
// Constants and types shared by the data EEPROM access controller
package dea_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_ADR_LO  = 8'h04;
  localparam logic [7:0] ADDR_ADR_HI  = 8'h08;
  localparam logic [7:0] ADDR_KEY     = 8'h0C;
  localparam logic [7:0] ADDR_FLAG    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h14;
  localparam logic [7:0] ADDR_PAGE    = 8'h18;
  localparam logic [7:0] ADDR_PTR     = 8'h1C;
  localparam logic [7:0] ADDR_TDATA   = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_START_BIT = 15;
  localparam int CTRL_WRITE_ENABLE_BIT  = 14;
  localparam int CTRL_ERR_BIT   = 13;
  localparam int OP_W           = 7;
  localparam int OP_ERASE_BIT   = 6;
  localparam int DONE_BIT       = 0;
  localparam int IRQ_EN_BIT     = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Operation codes
  localparam logic [6:0] OP_BLOCK_ERASE = 7'h45;
  localparam logic [6:0] OP_WORD_ERASE  = 7'h44;
  localparam logic [6:0] OP_WORD_PROG   = 7'h04;
  localparam logic [6:0] OP_BLOCK_PROG  = 7'h0A;

  ////////////////////////////////////////////////////////////////////////////
  // Memory map, keys and reset values
  localparam logic [23:0] EE_BASE_ADDR = 24'h7FF000;
  localparam logic [23:0] EE_LAST_ADDR = 24'h7FFFFE;
  localparam int          EE_WORDS     = 4096;
  localparam int          BLOCK_WORDS  = 16;
  localparam logic [7:0]  KEY_FIRST    = 8'h55;
  localparam logic [7:0]  KEY_SECOND   = 8'hAA;
  localparam logic [15:0] ERASED_WORD  = 16'hFFFF;
  localparam logic [6:0]  OP_RST       = 7'h00;
  localparam logic [15:0] ADR_LO_RST   = 16'h0000;
  localparam logic [7:0]  ADR_HI_RST   = 8'h00;
  localparam logic [7:0]  PAGE_RST     = 8'h00;
  localparam logic [15:0] PTR_RST      = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: typical erase or program time and core clock period
  localparam int unsigned CYCLE_TIME_NS = 2000000;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned CYCLE_CLKS =
    (CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // State encodings
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_WAIT   = 3'b010,
    ST_COMMIT = 3'b100
  } dea_cyc_e;

  typedef enum logic [2:0] {
    KEY_IDLE  = 3'b001,
    KEY_FIRST_OK = 3'b010,
    KEY_ARMED = 3'b100
  } dea_key_e;

endpackage : dea_pkg

// ### design/dea_sync2.sv
// Two flip-flop synchroniser for one level
`timescale 1ns/1ns
`default_nettype none
module dea_sync2 (
  input  wire logic i_clk,   // Core clock
  input  wire logic i_rst_n, // Async reset, active low
  input  wire logic i_async, // Level from another domain
  output logic      o_sync   // Synchronised level
);

  logic meta_reg;

  // First stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= 1'b0;
      o_sync   <= 1'b0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end

endmodule : dea_sync2
`default_nettype wire

// ### design/dea_eeprom_mem.sv
// Word array of the data EEPROM with one write and one read port
`timescale 1ns/1ns
`default_nettype none
module dea_eeprom_mem #(
  parameter int DW = 16,
  parameter int AW = 12
) (
  input  wire logic          i_clk,     // Core clock
  input  wire logic          i_rst_n,   // Async reset, active low
  input  wire logic          i_wr_en,   // Write strobe
  input  wire logic [AW-1:0] i_wr_addr, // Word index to write
  input  wire logic [DW-1:0] i_wr_data, // Word to write
  input  wire logic [AW-1:0] i_rd_addr, // Word index to read
  output logic      [DW-1:0] o_rd_data  // Registered read word
);

  logic [DW-1:0] mem_arr [0:(1<<AW)-1];

  // Cell update, no reset: contents are nonvolatile
  always_ff @(posedge i_clk) begin
    if (i_wr_en) begin
      mem_arr[i_wr_addr] <= i_wr_data;
    end
  end

  // Read port, follows the address every cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= mem_arr[i_rd_addr];
    end
  end

endmodule : dea_eeprom_mem
`default_nettype wire

// ### design/dea_ctrl.sv
// Data EEPROM access controller with APB register slave
`timescale 1ns/1ns
`default_nettype none
module dea_ctrl #(
  parameter int unsigned P_CYCLE_CLKS = dea_pkg::CYCLE_CLKS
) (
  input  wire logic        I_CORE_CLK,       // Core clock, 250 MHz
  input  wire logic        I_RST_N,          // Power-up reset, active low
  input  wire logic        I_PSEL,           // APB select
  input  wire logic        I_PENABLE,        // APB enable
  input  wire logic        I_PWRITE,         // APB direction, 1 write
  input  wire logic [7:0]  I_PADDR,          // APB byte address
  input  wire logic [31:0] I_PWDATA,         // APB write data
  input  wire logic        I_EXT_RESET_PIN,  // External reset pin level
  input  wire logic        I_WATCHDOG_RST,   // Watchdog timeout reset level
  input  wire logic        I_PWRUP_TIMER_RUN,// Power-up timer running
  output logic      [31:0] O_PRDATA,         // APB read data
  output logic             O_PREADY,         // APB ready
  output logic             O_PSLVERR,        // APB error, unmapped address
  output logic             O_NVM_IRQ,        // Completion interrupt request
  output logic             O_CYCLE_ACTIVE    // Erase or program running
);

  localparam int AW    = $clog2(dea_pkg::EE_WORDS);
  localparam int BW    = $clog2(dea_pkg::BLOCK_WORDS);
  localparam int CNT_W = $clog2(P_CYCLE_CLKS + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(P_CYCLE_CLKS - 1);
  localparam logic [BW-1:0]    STEP_LAST = BW'(dea_pkg::BLOCK_WORDS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                write_start_reg;
  logic                write_enable_reg;
  logic                write_error_flag_reg;
  logic [6:0]          op_reg;
  logic [15:0]         nvm_addr_low_reg;
  logic [7:0]          nvm_addr_high_reg;
  logic [7:0]          table_page_reg;
  logic [15:0]         table_ptr_reg;
  logic                nvm_done_flag_reg;
  logic                irq_en_reg;
  logic [15:0]         latch_arr [0:dea_pkg::BLOCK_WORDS-1];
  dea_pkg::dea_key_e   key_st_reg;
  dea_pkg::dea_cyc_e   cyc_st_reg;
  logic [CNT_W-1:0]    cnt_reg;
  logic [BW-1:0]       step_reg;
  logic [6:0]          run_op_reg;
  logic [23:0]         run_addr_reg;
  logic                ext_rst_s;
  logic                wdt_rst_s;
  logic                por_run_s;
  logic                setup_ph;
  logic                bus_wr;
  logic                start_req;
  logic                abort;
  logic                cyc_end;
  logic                run_is_block;
  logic                run_is_erase;
  logic                run_valid;
  logic                mem_we;
  logic [AW-1:0]       mem_wr_addr;
  logic [15:0]         mem_wr_data;
  logic [AW-1:0]       mem_rd_addr;
  logic [15:0]         mem_rd_data;
  logic [23:0]         tbl_addr;
  logic                tbl_in_range;
  logic [31:0]         rd_mux;
  logic                rd_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Pin level synchronisers
  dea_sync2 u_sync_ext (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_async (I_EXT_RESET_PIN),
    .o_sync  (ext_rst_s)
  );

  dea_sync2 u_sync_wdt (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_async (I_WATCHDOG_RST),
    .o_sync  (wdt_rst_s)
  );

  dea_sync2 u_sync_por (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_async (I_PWRUP_TIMER_RUN),
    .o_sync  (por_run_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus phase decode
  assign setup_ph = I_PSEL & ~I_PENABLE;
  assign bus_wr   = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;

  // Start needs armed keys and an enable set by an earlier write
  assign start_req = bus_wr && (I_PADDR == dea_pkg::ADDR_CTRL)
                   && I_PWDATA[dea_pkg::CTRL_START_BIT]
                   && !write_start_reg
                   && write_enable_reg
                   && (key_st_reg == dea_pkg::KEY_ARMED)
                   && !por_run_s
                   && !ext_rst_s && !wdt_rst_s;

  // Pin or watchdog reset cuts an active cycle short
  assign abort = write_start_reg & (ext_rst_s | wdt_rst_s);

  ////////////////////////////////////////////////////////////////////////////
  // Operation decode of the latched code
  assign run_is_erase = run_op_reg[dea_pkg::OP_ERASE_BIT];
  assign run_is_block = (run_op_reg == dea_pkg::OP_BLOCK_ERASE)
                     || (run_op_reg == dea_pkg::OP_BLOCK_PROG);
  assign run_valid = ((run_op_reg == dea_pkg::OP_BLOCK_ERASE)
                   || (run_op_reg == dea_pkg::OP_WORD_ERASE)
                   || (run_op_reg == dea_pkg::OP_WORD_PROG)
                   || (run_op_reg == dea_pkg::OP_BLOCK_PROG))
                   && (run_addr_reg >= dea_pkg::EE_BASE_ADDR)
                   && (run_addr_reg <= dea_pkg::EE_LAST_ADDR);

  assign cyc_end = (cyc_st_reg == dea_pkg::ST_COMMIT)
                 && (!run_is_block || step_reg == STEP_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Array write port: one word, or each word of the block in turn
  always_comb begin
    mem_we      = (cyc_st_reg == dea_pkg::ST_COMMIT) && run_valid && !abort;
    mem_wr_addr = run_addr_reg[AW:1];
    mem_wr_data = latch_arr[run_addr_reg[BW:1]];
    if (run_is_block) begin
      mem_wr_addr = {run_addr_reg[AW:BW+1], step_reg};
      mem_wr_data = latch_arr[step_reg];
    end
    if (run_is_erase) begin
      mem_wr_data = dea_pkg::ERASED_WORD;
    end
  end

  // Table read address from page and pointer
  assign tbl_addr     = {table_page_reg, table_ptr_reg};
  assign tbl_in_range = (tbl_addr >= dea_pkg::EE_BASE_ADDR)
                     && (tbl_addr <= dea_pkg::EE_LAST_ADDR);
  assign mem_rd_addr  = tbl_addr[AW:1];

  dea_eeprom_mem #(
    .DW (16),
    .AW (AW)
  ) u_mem (
    .i_clk     (I_CORE_CLK),
    .i_rst_n   (I_RST_N),
    .i_wr_en   (mem_we),
    .i_wr_addr (mem_wr_addr),
    .i_wr_data (mem_wr_data),
    .i_rd_addr (mem_rd_addr),
    .o_rd_data (mem_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer: wait the cycle time, then commit the words
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cyc_st_reg   <= dea_pkg::ST_IDLE;
      cnt_reg      <= '0;
      step_reg     <= '0;
      run_op_reg   <= dea_pkg::OP_RST;
      run_addr_reg <= '0;
    end else if (abort) begin
      cyc_st_reg <= dea_pkg::ST_IDLE;
    end else begin
      unique case (cyc_st_reg)
        dea_pkg::ST_IDLE: begin
          if (start_req) begin
            cyc_st_reg   <= dea_pkg::ST_WAIT;
            cnt_reg      <= '0;
            run_op_reg   <= I_PWDATA[dea_pkg::OP_W-1:0];
            run_addr_reg <= {nvm_addr_high_reg, nvm_addr_low_reg};
          end
        end
        dea_pkg::ST_WAIT: begin
          cnt_reg <= cnt_reg + CNT_W'(1);
          if (cnt_reg == CNT_LAST) begin
            cyc_st_reg <= dea_pkg::ST_COMMIT;
            step_reg   <= '0;
          end
        end
        dea_pkg::ST_COMMIT: begin
          step_reg <= step_reg + BW'(1);
          if (cyc_end) begin
            cyc_st_reg <= dea_pkg::ST_IDLE;
          end
        end
        default: begin
          cyc_st_reg <= dea_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unlock tracker: 55 then AA arms, any other write disarms
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      key_st_reg <= dea_pkg::KEY_IDLE;
    end else if (bus_wr) begin
      if (I_PADDR != dea_pkg::ADDR_KEY) begin
        key_st_reg <= dea_pkg::KEY_IDLE;
      end else if (I_PWDATA[7:0] == dea_pkg::KEY_FIRST) begin
        key_st_reg <= dea_pkg::KEY_FIRST_OK;
      end else if (I_PWDATA[7:0] == dea_pkg::KEY_SECOND
                   && key_st_reg == dea_pkg::KEY_FIRST_OK) begin
        key_st_reg <= dea_pkg::KEY_ARMED;
      end else begin
        key_st_reg <= dea_pkg::KEY_IDLE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register: start set by hardware gate only, enable by software
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      write_start_reg  <= 1'b0;
      write_enable_reg <= 1'b0;
      op_reg           <= dea_pkg::OP_RST;
    end else begin
      if (start_req) begin
        write_start_reg <= 1'b1;
      end else if (cyc_end || abort) begin
        write_start_reg <= 1'b0;
      end
      if (bus_wr && I_PADDR == dea_pkg::ADDR_CTRL) begin
        write_enable_reg <= I_PWDATA[dea_pkg::CTRL_WRITE_ENABLE_BIT];
        op_reg           <= I_PWDATA[dea_pkg::OP_W-1:0];
      end
    end
  end

  // Error flag: set wins over a software clear
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      write_error_flag_reg <= 1'b0;
    end else if (abort) begin
      write_error_flag_reg <= 1'b1;
    end else if (bus_wr && I_PADDR == dea_pkg::ADDR_CTRL
                 && !I_PWDATA[dea_pkg::CTRL_ERR_BIT]) begin
      write_error_flag_reg <= 1'b0;
    end
  end

  // Done flag and interrupt request
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      nvm_done_flag_reg <= 1'b0;
      irq_en_reg        <= 1'b0;
      O_NVM_IRQ         <= 1'b0;
    end else begin
      if (cyc_end && !abort) begin
        nvm_done_flag_reg <= 1'b1;
      end else if (bus_wr && I_PADDR == dea_pkg::ADDR_FLAG
                   && !I_PWDATA[dea_pkg::DONE_BIT]) begin
        nvm_done_flag_reg <= 1'b0;
      end
      if (bus_wr && I_PADDR == dea_pkg::ADDR_IRQ_EN) begin
        irq_en_reg <= I_PWDATA[dea_pkg::IRQ_EN_BIT];
      end
      O_NVM_IRQ <= nvm_done_flag_reg & irq_en_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address registers; a table write captures its address
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      nvm_addr_low_reg  <= dea_pkg::ADR_LO_RST;
      nvm_addr_high_reg <= dea_pkg::ADR_HI_RST;
      table_page_reg    <= dea_pkg::PAGE_RST;
      table_ptr_reg     <= dea_pkg::PTR_RST;
    end else if (bus_wr) begin
      unique case (I_PADDR)
        dea_pkg::ADDR_ADR_LO: nvm_addr_low_reg  <= I_PWDATA[15:0];
        dea_pkg::ADDR_ADR_HI: nvm_addr_high_reg <= I_PWDATA[7:0];
        dea_pkg::ADDR_PAGE:   table_page_reg    <= I_PWDATA[7:0];
        dea_pkg::ADDR_PTR:    table_ptr_reg     <= I_PWDATA[15:0];
        dea_pkg::ADDR_TDATA: begin
          nvm_addr_low_reg  <= table_ptr_reg;
          nvm_addr_high_reg <= table_page_reg;
        end
        default: begin
        end
      endcase
    end
  end

  // Write latches, selected by pointer bits of the table write
  always_ff @(posedge I_CORE_CLK) begin
    if (bus_wr && I_PADDR == dea_pkg::ADDR_TDATA) begin
      latch_arr[table_ptr_reg[BW:1]] <= I_PWDATA[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection for the setup cycle
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (I_PADDR)
      dea_pkg::ADDR_CTRL: begin
        rd_mux[dea_pkg::CTRL_START_BIT] = write_start_reg;
        rd_mux[dea_pkg::CTRL_WRITE_ENABLE_BIT]  = write_enable_reg;
        rd_mux[dea_pkg::CTRL_ERR_BIT]   = write_error_flag_reg;
        rd_mux[dea_pkg::OP_W-1:0]       = op_reg;
      end
      dea_pkg::ADDR_ADR_LO: rd_mux[15:0] = nvm_addr_low_reg;
      dea_pkg::ADDR_ADR_HI: rd_mux[7:0]  = nvm_addr_high_reg;
      dea_pkg::ADDR_KEY:    rd_mux       = '0;
      dea_pkg::ADDR_FLAG:   rd_mux[dea_pkg::DONE_BIT] = nvm_done_flag_reg;
      dea_pkg::ADDR_IRQ_EN: rd_mux[dea_pkg::IRQ_EN_BIT] = irq_en_reg;
      dea_pkg::ADDR_PAGE:   rd_mux[7:0]  = table_page_reg;
      dea_pkg::ADDR_PTR:    rd_mux[15:0] = table_ptr_reg;
      dea_pkg::ADDR_TDATA: begin
        // Array word, unspecified while a cycle runs
        if (tbl_in_range) begin
          rd_mux[15:0] = mem_rd_data;
        end
      end
      default: rd_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: ready and data registered in the setup cycle
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= '0;
    end else begin
      O_PREADY  <= setup_ph;
      O_PSLVERR <= setup_ph & ~rd_hit;
      if (setup_ph && !I_PWRITE) begin
        O_PRDATA <= rd_mux;
      end
    end
  end

  // Busy indication for software-free observation
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_CYCLE_ACTIVE <= 1'b0;
    end else begin
      O_CYCLE_ACTIVE <= start_req | (write_start_reg & ~cyc_end & ~abort);
    end
  end

endmodule : dea_ctrl
`default_nettype wire

// ### bench/dea_ctrl_sva.sv
// Port checker for the data EEPROM access controller
`timescale 1ns/1ns
`default_nettype none
module dea_ctrl_sva #(parameter int unsigned P_CYCLE_CLKS = 20) (
  input wire logic        I_CORE_CLK, I_RST_N, I_PSEL, I_PENABLE, I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA, O_PRDATA,
  input wire logic        I_EXT_RESET_PIN, I_WATCHDOG_RST, I_PWRUP_TIMER_RUN,
  input wire logic        O_PREADY, O_PSLVERR, O_NVM_IRQ, O_CYCLE_ACTIVE
);
  logic        en_reg;
  logic [3:0]  pin_reg;
  int unsigned cnt_reg;
  wire acc = I_PSEL && I_PENABLE && O_PREADY;
  wire map = I_PADDR <= 8'h20 && I_PADDR[1:0] == 2'h0;
  wire stw = acc && I_PWRITE && I_PADDR == 8'h00 && I_PWDATA[15];
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  // Shadow of the interrupt enable, pin history and run length
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      en_reg  <= 1'b0;
      pin_reg <= 4'h0;
      cnt_reg <= 0;
    end else begin
      if (acc && I_PWRITE && I_PADDR == 8'h14) en_reg <= I_PWDATA[0];
      pin_reg <= {pin_reg[2:0], I_EXT_RESET_PIN | I_WATCHDOG_RST
                  | I_PWRUP_TIMER_RUN};
      cnt_reg <= O_CYCLE_ACTIVE ? cnt_reg + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_ready_next: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("ready missing after setup");
  chk_ready_once: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready held too long");
  chk_err_unmap: assert property (acc && !map |-> O_PSLVERR)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (acc && map |-> !O_PSLVERR)
    else $error("mapped access refused");
  chk_start_cause: assert property ($rose(O_CYCLE_ACTIVE) |->
    $past(stw))
    else $error("cycle began without a start write");
  chk_start_clean: assert property ($rose(O_CYCLE_ACTIVE) |->
    !pin_reg[2]) else $error("cycle began while blocked");
  chk_run_len: assert property ($fell(O_CYCLE_ACTIVE) && !pin_reg |->
    cnt_reg >= P_CYCLE_CLKS && cnt_reg <= P_CYCLE_CLKS + 18)
    else $error("cycle length out of range");
  chk_abort_stop: assert property (O_CYCLE_ACTIVE &&
    (I_EXT_RESET_PIN || I_WATCHDOG_RST) |-> ##[1:4] !O_CYCLE_ACTIVE)
    else $error("cycle not aborted");
  chk_irq_raise: assert property ($fell(O_CYCLE_ACTIVE) && en_reg &&
    !pin_reg |-> ##[0:2] O_NVM_IRQ) else $error("interrupt missing");
  chk_irq_gate: assert property (!en_reg && !$past(en_reg) |->
    !O_NVM_IRQ) else $error("interrupt while disabled");
  cov_start: cover property ($rose(O_CYCLE_ACTIVE));
  cov_irq: cover property ($rose(O_NVM_IRQ));
  cov_err: cover property (acc && O_PSLVERR);
  cov_abort: cover property ($fell(O_CYCLE_ACTIVE) && pin_reg != 4'h0);
endmodule : dea_ctrl_sva
bind dea_ctrl dea_ctrl_sva #(.P_CYCLE_CLKS(P_CYCLE_CLKS)) u_sva (
  .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .I_EXT_RESET_PIN(I_EXT_RESET_PIN), .I_WATCHDOG_RST(I_WATCHDOG_RST),
  .I_PWRUP_TIMER_RUN(I_PWRUP_TIMER_RUN), .O_PSLVERR(O_PSLVERR),
  .O_NVM_IRQ(O_NVM_IRQ), .O_CYCLE_ACTIVE(O_CYCLE_ACTIVE));
`default_nettype wire

// ### bench/dea_core_model.sv
// Processor core model issuing register bus transfers
`timescale 1ns/1ns
`default_nettype none
module dea_core_model (
  input  wire logic        i_clk,     // Core clock
  input  wire logic [31:0] i_prdata,  // Read data
  input  wire logic        i_pready,  // Ready
  input  wire logic        i_pslverr, // Error
  output logic             o_psel,    // Select
  output logic             o_penable, // Enable
  output logic             o_pwrite,  // Direction
  output logic      [7:0]  o_paddr,   // Address
  output logic      [31:0] o_pwdata   // Write data
);
  // Idle bus at time zero
  initial begin
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    o_pwrite  <= 1'b0;
    o_paddr   <= 8'h00;
    o_pwdata  <= 32'h0;
  end
  // Setup, access until ready, then release with scrambled lines
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge i_clk);
    o_psel   <= 1'b1;
    o_pwrite <= w;
    o_paddr  <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (i_pready !== 1'b1);
    r = i_prdata;
    e = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    o_paddr   <= ~a;
    o_pwdata  <= ~d;
  endtask : xfer
endmodule : dea_core_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the data EEPROM access controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, x); end end
module testbench;
  localparam int unsigned CYC = 20;
  logic clk = 1'b0, rst_n = 1'b0, ext = 1'b0, wdt = 1'b0, pwr = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, act, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  int err_count = 0, checks = 0;
  // Core clock
  always #2 clk = ~clk;
  dea_ctrl #(.P_CYCLE_CLKS(CYC)) dut (.I_CORE_CLK(clk), .I_RST_N(rst_n),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .I_EXT_RESET_PIN(ext), .I_WATCHDOG_RST(wdt),
    .I_PWRUP_TIMER_RUN(pwr), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_NVM_IRQ(irq), .O_CYCLE_ACTIVE(act));
  dea_core_model core (.i_clk(clk), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata));
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    core.xfer(1'b1, a, d, rdv, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    core.xfer(1'b0, a, 32'h0, rdv, e);
    `CHK(rdv, x)
  endtask : rd
  // Two keys, then the control write
  task automatic unlock(input logic [7:0] k1, k2, input logic [15:0] c);
    wr(8'h0C, {24'h0, k1});
    wr(8'h0C, {24'h0, k2});
    wr(8'h00, {16'h0, c});
  endtask : unlock
  // Poll the start bit until hardware clears it
  task automatic wait_idle;
    do begin
      core.xfer(1'b0, 8'h00, 32'h0, rdv, e);
    end while (rdv[15] !== 1'b0);
  endtask : wait_idle
  task automatic tally_and_finish;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // Watchdog against a hang
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) rd(8'(4 * i), 32'h0);
    rd(8'h24, 32'h0);
    `CHK(e, 1'b1)
    wr(8'h14, 32'h1);
    wr(8'h18, 32'h7F);
    wr(8'h1C, 32'hF010);
    wr(8'h20, 32'h1234);
    rd(8'h04, 32'hF010);
    rd(8'h08, 32'h7F);
    wr(8'h00, 32'h4044);
    unlock(8'h55, 8'hAA, 16'hC044);
    wait_idle();
    rd(8'h20, 32'hFFFF);
    rd(8'h00, 32'h4044);
    rd(8'h10, 32'h1);
    `CHK(irq, 1'b1)
    wr(8'h10, 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h00, 32'h4004);
    unlock(8'h55, 8'hAA, 16'hC004);
    wait_idle();
    rd(8'h20, 32'h1234);
    // Block: fill latches, erase, program, read back
    for (int i = 0; i < 16; i++) begin
      wr(8'h1C, 32'hF020 + 2 * i);
      wr(8'h20, 32'hA0 + i);
    end
    wr(8'h00, 32'h4045);
    unlock(8'h55, 8'hAA, 16'hC045);
    wait_idle();
    wr(8'h1C, 32'hF024);
    rd(8'h20, 32'hFFFF);
    wr(8'h00, 32'h400A);
    unlock(8'h55, 8'hAA, 16'hC00A);
    wait_idle();
    for (int i = 0; i < 16; i++) begin
      wr(8'h1C, 32'hF020 + 2 * i);
      rd(8'h20, 32'hA0 + i);
    end
    // Refused starts
    wr(8'h00, 32'h0044);
    unlock(8'h55, 8'hAA, 16'hC044);
    rd(8'h00, 32'h4044);
    unlock(8'hAA, 8'h55, 16'hC044);
    rd(8'h00, 32'h4044);
    wr(8'h0C, 32'h55);
    unlock(8'h12, 8'hAA, 16'hC044);
    rd(8'h00, 32'h4044);
    pwr <= 1'b1;
    repeat (6) @(posedge clk);
    unlock(8'h55, 8'hAA, 16'hC044);
    rd(8'h00, 32'h4044);
    pwr <= 1'b0;
    repeat (6) @(posedge clk);
    // Software cannot clear a running cycle
    wr(8'h10, 32'h0);
    unlock(8'h55, 8'hAA, 16'hC044);
    wr(8'h00, 32'h0044);
    rd(8'h00, 32'h8044);
    `CHK(act, 1'b1)
    wait_idle();
    `CHK(act, 1'b0)
    wr(8'h14, 32'h0);
    rd(8'h10, 32'h1);
    `CHK(irq, 1'b0)
    // Pin reset then watchdog abort a running cycle
    for (int j = 0; j < 2; j++) begin
      wr(8'h10, 32'h0);
      wr(8'h00, 32'h4044);
      unlock(8'h55, 8'hAA, 16'hC044);
      repeat (5) @(posedge clk);
      {wdt, ext} <= 2'(j + 1);
      repeat (6) @(posedge clk);
      {wdt, ext} <= 2'b00;
      repeat (CYC) @(posedge clk);
      rd(8'h00, 32'h6044);
      rd(8'h04, 32'hF03E);
      rd(8'h10, 32'h0);
    end
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h0);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
